// [core/tsa_pkg.sv]
// Constants and types shared by the thermal sensor register and alert block.
`default_nettype none
package tsa_pkg;

  // ----------------------------------------------------------------
  // Command indexes
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_LOCAL_TEMP = 8'h00;
  localparam logic [7:0] REG_REMOTE_TEMP = 8'h01;
  localparam logic [7:0] REG_ALARM_FLAGS = 8'h02;
  localparam logic [7:0] REG_SETTINGS_RD = 8'h03;
  localparam logic [7:0] REG_LLIM_RD = 8'h05;
  localparam logic [7:0] REG_RLIM_RD = 8'h07;
  localparam logic [7:0] REG_SETTINGS_WR = 8'h09;
  localparam logic [7:0] REG_LLIM_WR = 8'h0B;
  localparam logic [7:0] REG_RLIM_WR = 8'h0D;
  localparam logic [7:0] REG_ONE_CONV = 8'h0F;
  localparam logic [7:0] REG_REMOTE_FRAC = 8'h10;
  localparam logic [7:0] REG_LOCAL_FRAC = 8'h11;
  localparam logic [7:0] REG_MAKER = 8'hFE;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CFG_IRQ_DISABLE_BIT = 7;
  localparam int CFG_STANDBY_BIT = 6;
  localparam int CFG_REMOTE_ONLY_BIT = 5;
  localparam int CFG_QUEUE_BIT = 4;
  localparam int ST_BUSY_BIT = 7;
  localparam int ST_LOCAL_OVER_BIT = 6;
  localparam int ST_REMOTE_OVER_BIT = 4;
  localparam int ST_DIODE_BIT = 2;
  localparam logic [7:0] CFG_WR_MASK = 8'hF0;
  localparam logic [7:0] CFG_RESET = 8'h10;
  localparam logic [7:0] LLIM_RESET = 8'h46;
  localparam logic [7:0] RLIM_RESET = 8'h78;
  localparam logic [7:0] TEMP_FAULT = 8'hFF;
  localparam logic [7:0] TEMP_TOP_VALID = 8'hFE;
  localparam logic [6:0] ARA_ADDR = 7'h0C;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int CONV_TIME_MS = 125;
  localparam int CONV_CYCLES = CLK_HZ / 1000 * CONV_TIME_MS;
  localparam int CNT_W = 21;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {KIND_CMD, KIND_DATA, KIND_READ, KIND_ARA} lnk_kind_t;
  typedef enum logic [1:0] {CS_IDLE, CS_LOCAL, CS_REMOTE} conv_state_t;
  typedef struct packed {
    lnk_kind_t kind;
    logic [7:0] data;
  } lnk_req_t;
  typedef struct packed {
    logic ack;
    logic [7:0] data;
  } lnk_rsp_t;
  typedef struct packed {
    logic below_zero;
    logic [7:0] whole;
    logic [1:0] frac;
  } adc_sample_t;

endpackage : tsa_pkg

`default_nettype wire

// [core/tsa_core.sv]
// Register set, conversion sequencer and latched alert of the sensor.
// How it works
// - Receive Byte returns register at command pointer.
// - Local result index 00h, remote 01h.
// - Fraction bits 7:6 at 10h and 11h.
// - Main and fraction results update together.
// - Reading at or above limit raises alert.
// - Limits reset to 70 and 120 degrees.
// - Diode fault loads all ones, sets flag.
// - Diode fault never alerts; flagged after conversion.
// - Unsigned result, negatives clamp, all ones reserved.
// - Alert latched; clears by ARA, or by status read once both conditions gone.
// - Condition persisting reasserts after next conversion.
// - Raising limit above reading clears alert unless other channel still over.
// - Alerting device answers ARA with its address.
// - Config and limits written at 09h/0Bh/0Dh.
// - Status, config, limits read at 02h/03h/05h/07h.
// - Config bit 7 disables alert.
// - Config bit 6 selects standby.
// - Config bit 5 converts remote channel only.
// - Config bit 4 needs two faults; resets one.
// - Status bit 7 shows conversion busy.
// - Over flags clear on status read.
// - Diode flag clears on read once gone.
// - Command pointer resets to zero.
// - Single shot works only in idle standby.
// - Standby aborts conversion, keeps old result.
`timescale 1ns/1ns
`default_nettype none

module tsa_core #(
  parameter int CONV_CYCLES = tsa_pkg::CONV_CYCLES,
  parameter logic [6:0] SLAVE_ADDR = 7'h48,
  parameter logic [7:0] MAKER_ID = 8'h5A // Arbitrary value.
) (
  input wire logic i_core_clk, // Core clock, 10 MHz.
  input wire logic i_rst, // Core reset, synchronous, high.
  input wire logic i_lnk_clk, // Link-side clock.
  input wire logic i_lnk_rst, // Link reset, synchronous, high.
  input wire logic i_lnk_req_valid, // Transfer request offered.
  input wire tsa_pkg::lnk_req_t i_lnk_req, // Request kind and byte.
  output logic o_lnk_req_ready, // Request can be taken.
  output logic o_lnk_rsp_valid, // Answer pulse.
  output tsa_pkg::lnk_rsp_t o_lnk_rsp, // Answer ack and byte.
  input wire tsa_pkg::adc_sample_t i_adc_sample, // Converter result.
  input wire logic i_diode_fault, // Remote diode open or short.
  output logic o_adc_remote, // Channel being converted.
  output logic o_adc_busy, // Converter running.
  output logic o_alert_o, // Alert pin drive level.
  output logic o_alert_oe_n // Alert pin enable, low drives.
);

  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ptr;
    logic [7:0] cfg;
    logic [7:0] llim;
    logic [7:0] rlim;
    logic [7:0] ltemp;
    logic [7:0] rtemp;
    logic [1:0] lfrac;
    logic [1:0] rfrac;
    logic st_lover;
    logic st_rover;
    logic st_diode;
    logic diode_now;
    logic lcond;
    logic rcond;
    logic lprev;
    logic rprev;
    logic alert;
    tsa_pkg::conv_state_t cs;
    logic one_shot;
    logic [tsa_pkg::CNT_W-1:0] cnt;
    logic req_s1;
    logic req_s2;
    logic req_s3;
    logic ack_tog;
    tsa_pkg::lnk_rsp_t rsp;
    logic dflt_s1;
    logic dflt_s2;
  } tsa_core_st_t;

  typedef struct packed {
    logic req_tog;
    logic pend;
    tsa_pkg::lnk_req_t req;
    logic ack_s1;
    logic ack_s2;
    logic ack_s3;
    logic rsp_v;
    tsa_pkg::lnk_rsp_t rsp;
  } tsa_lnk_st_t;

  tsa_core_st_t c_q;
  tsa_core_st_t c_d;
  tsa_lnk_st_t l_q;
  tsa_lnk_st_t l_d;
  logic [7:0] rd_data;
  logic [7:0] smp_whole;
  logic [1:0] smp_frac;
  logic req_new;
  logic conv_end;
  logic l_over;
  logic r_over;

  // ----------------------------------------------------------------
  // Read data selection
  // ----------------------------------------------------------------
  // Write-only indexes and holes read as zero.
  always_comb
  begin
    rd_data = '0;
    case (c_q.ptr)
      tsa_pkg::REG_LOCAL_TEMP: rd_data = c_q.ltemp;
      tsa_pkg::REG_REMOTE_TEMP: rd_data = c_q.rtemp;
      tsa_pkg::REG_ALARM_FLAGS:
      begin
        rd_data[tsa_pkg::ST_BUSY_BIT] = (c_q.cs != tsa_pkg::CS_IDLE);
        rd_data[tsa_pkg::ST_LOCAL_OVER_BIT] = c_q.st_lover;
        rd_data[tsa_pkg::ST_REMOTE_OVER_BIT] = c_q.st_rover;
        rd_data[tsa_pkg::ST_DIODE_BIT] = c_q.st_diode;
      end
      tsa_pkg::REG_SETTINGS_RD: rd_data = c_q.cfg;
      tsa_pkg::REG_LLIM_RD: rd_data = c_q.llim;
      tsa_pkg::REG_RLIM_RD: rd_data = c_q.rlim;
      tsa_pkg::REG_REMOTE_FRAC: rd_data = {c_q.rfrac, 6'h00};
      tsa_pkg::REG_LOCAL_FRAC: rd_data = {c_q.lfrac, 6'h00};
      tsa_pkg::REG_MAKER: rd_data = MAKER_ID;
      default: rd_data = '0;
    endcase
  end

  // ----------------------------------------------------------------
  // Sample conditioning
  // ----------------------------------------------------------------
  // clamp range
  // All ones is kept free so that it can only mean a diode fault.
  always_comb
  begin
    if (i_adc_sample.below_zero)
    begin
      smp_whole = '0;
      smp_frac = '0;
    end
    else if (i_adc_sample.whole == tsa_pkg::TEMP_FAULT)
    begin
      smp_whole = tsa_pkg::TEMP_TOP_VALID;
      smp_frac = i_adc_sample.frac;
    end
    else
    begin
      smp_whole = i_adc_sample.whole;
      smp_frac = i_adc_sample.frac;
    end
  end

  // Request edge and conversion end, plus limit compares.
  assign req_new = c_q.req_s2 ^ c_q.req_s3;
  assign conv_end = (c_q.cs != tsa_pkg::CS_IDLE)
    && (c_q.cnt == tsa_pkg::CNT_W'(CONV_CYCLES - 1));
  assign l_over = smp_whole >= c_q.llim;
  assign r_over = smp_whole >= c_q.rlim;

  // ----------------------------------------------------------------
  // Core next state
  // ----------------------------------------------------------------
  // Requests are handled before conversion results, so a flag set by
  // a finishing conversion wins over a clear in the same cycle.
  always_comb
  begin
    c_d = c_q;
    c_d.dflt_s1 = i_diode_fault;
    c_d.dflt_s2 = c_q.dflt_s1;
    c_d.req_s1 = l_q.req_tog;
    c_d.req_s2 = c_q.req_s1;
    c_d.req_s3 = c_q.req_s2;

    // The request word is stable while its toggle is in flight.
    if (req_new)
    begin
      c_d.ack_tog = ~c_q.ack_tog;
      c_d.rsp.ack = 1'b1;
      c_d.rsp.data = '0;
      case (l_q.req.kind)
        tsa_pkg::KIND_CMD:
        begin
          c_d.ptr = l_q.req.data;
          if (l_q.req.data == tsa_pkg::REG_ONE_CONV
              && c_q.cfg[tsa_pkg::CFG_STANDBY_BIT]
              && c_q.cs == tsa_pkg::CS_IDLE)
          begin
            c_d.one_shot = 1'b1;
            c_d.cnt = '0;
            c_d.cs = c_q.cfg[tsa_pkg::CFG_REMOTE_ONLY_BIT]
              ? tsa_pkg::CS_REMOTE : tsa_pkg::CS_LOCAL;
          end
        end
        tsa_pkg::KIND_DATA:
        begin
          case (c_q.ptr)
            tsa_pkg::REG_SETTINGS_WR: c_d.cfg = l_q.req.data & tsa_pkg::CFG_WR_MASK;
            // limit raised
            // Only a limit write may drop the alert; other writes leave it latched.
            tsa_pkg::REG_LLIM_WR:
            begin
              c_d.llim = l_q.req.data;
              c_d.lcond = c_q.ltemp >= l_q.req.data;
              c_d.alert = c_q.alert && (c_d.lcond || c_q.rcond);
            end
            tsa_pkg::REG_RLIM_WR:
            begin
              c_d.rlim = l_q.req.data;
              c_d.rcond = !c_q.diode_now && (c_q.rtemp >= l_q.req.data);
              c_d.alert = c_q.alert && (c_q.lcond || c_d.rcond);
            end
            default: c_d.ptr = c_q.ptr;
          endcase
        end
        tsa_pkg::KIND_READ:
        begin
          c_d.rsp.data = rd_data;
          if (c_q.ptr == tsa_pkg::REG_ALARM_FLAGS)
          begin
            c_d.st_lover = 1'b0;
            c_d.st_rover = 1'b0;
            // fault gone
            // The live detector decides, not the last remote result.
            if (!c_q.dflt_s2)
            begin
              c_d.st_diode = 1'b0;
            end
            if (!c_q.lcond && !c_q.rcond)
            begin
              c_d.alert = 1'b0;
            end
          end
        end
        default:
        begin
          c_d.rsp.ack = c_q.alert;
          c_d.rsp.data = {SLAVE_ADDR, 1'b0};
          c_d.alert = 1'b0;
        end
      endcase
    end

    // standby abort
    // Nothing is latched, so the last result stays readable.
    if (c_q.cs != tsa_pkg::CS_IDLE && !c_q.one_shot
        && c_q.cfg[tsa_pkg::CFG_STANDBY_BIT])
    begin
      c_d.cs = tsa_pkg::CS_IDLE;
    end
    else
    begin
      case (c_q.cs)
        tsa_pkg::CS_IDLE:
        begin
          if (!c_q.cfg[tsa_pkg::CFG_STANDBY_BIT])
          begin
            c_d.cnt = '0;
            c_d.cs = c_q.cfg[tsa_pkg::CFG_REMOTE_ONLY_BIT]
              ? tsa_pkg::CS_REMOTE : tsa_pkg::CS_LOCAL;
          end
        end
        tsa_pkg::CS_LOCAL:
        begin
          c_d.cnt = c_q.cnt + 1'b1;
          if (conv_end)
          begin
            c_d.ltemp = smp_whole;
            c_d.lfrac = smp_frac;
            c_d.lcond = l_over;
            c_d.lprev = l_over;
            c_d.cnt = '0;
            c_d.cs = tsa_pkg::CS_REMOTE;
            if (l_over && (!c_q.cfg[tsa_pkg::CFG_QUEUE_BIT] || c_q.lprev))
            begin
              c_d.st_lover = 1'b1;
              if (!c_q.cfg[tsa_pkg::CFG_IRQ_DISABLE_BIT])
              begin
                c_d.alert = 1'b1;
              end
            end
          end
        end
        tsa_pkg::CS_REMOTE:
        begin
          c_d.cnt = c_q.cnt + 1'b1;
          if (conv_end)
          begin
            c_d.cnt = '0;
            if (c_q.dflt_s2)
            begin
              c_d.rtemp = tsa_pkg::TEMP_FAULT;
              c_d.rfrac = '0;
              c_d.st_diode = 1'b1;
              c_d.diode_now = 1'b1;
              c_d.rcond = 1'b0;
              c_d.rprev = 1'b0;
            end
            else
            begin
              c_d.rtemp = smp_whole;
              c_d.rfrac = smp_frac;
              c_d.diode_now = 1'b0;
              c_d.rcond = r_over;
              c_d.rprev = r_over;
              if (r_over && (!c_q.cfg[tsa_pkg::CFG_QUEUE_BIT] || c_q.rprev))
              begin
                c_d.st_rover = 1'b1;
                if (!c_q.cfg[tsa_pkg::CFG_IRQ_DISABLE_BIT])
                begin
                  c_d.alert = 1'b1;
                end
              end
            end
            if (c_q.one_shot || c_q.cfg[tsa_pkg::CFG_STANDBY_BIT])
            begin
              c_d.one_shot = 1'b0;
              c_d.cs = tsa_pkg::CS_IDLE;
            end
            else
            begin
              c_d.cs = c_q.cfg[tsa_pkg::CFG_REMOTE_ONLY_BIT]
                ? tsa_pkg::CS_REMOTE : tsa_pkg::CS_LOCAL;
            end
          end
        end
        default: c_d.cs = tsa_pkg::CS_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Core registers
  // ----------------------------------------------------------------
  // limit reset
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      c_q <= '0;
      c_q.cfg <= tsa_pkg::CFG_RESET;
      c_q.llim <= tsa_pkg::LLIM_RESET;
      c_q.rlim <= tsa_pkg::RLIM_RESET;
      c_q.cs <= tsa_pkg::CS_IDLE;
    end
    else
    begin
      c_q <= c_d;
    end
  end

  // ----------------------------------------------------------------
  // Link side
  // ----------------------------------------------------------------
  // One request is in flight at a time; ready stalls the link until
  // the toggle has come back, which keeps the request word stable.
  always_comb
  begin
    l_d = l_q;
    l_d.ack_s1 = c_q.ack_tog;
    l_d.ack_s2 = l_q.ack_s1;
    l_d.ack_s3 = l_q.ack_s2;
    l_d.rsp_v = l_q.ack_s2 ^ l_q.ack_s3;
    if (l_q.ack_s2 ^ l_q.ack_s3)
    begin
      l_d.rsp = c_q.rsp;
      l_d.pend = 1'b0;
    end
    else if (i_lnk_req_valid && !l_q.pend)
    begin
      l_d.req = i_lnk_req;
      l_d.req_tog = ~l_q.req_tog;
      l_d.pend = 1'b1;
    end
  end

  always_ff @(posedge i_lnk_clk)
  begin
    if (i_lnk_rst)
    begin
      l_q <= '0;
    end
    else
    begin
      l_q <= l_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // latched drive
  // The pin is only pulled low; the line's pull-up gives the high.
  assign o_alert_o = 1'b0;
  assign o_alert_oe_n = ~c_q.alert;
  assign o_adc_remote = (c_q.cs == tsa_pkg::CS_REMOTE);
  assign o_adc_busy = (c_q.cs != tsa_pkg::CS_IDLE);
  assign o_lnk_req_ready = ~l_q.pend;
  assign o_lnk_rsp_valid = l_q.rsp_v;
  assign o_lnk_rsp = l_q.rsp;

endmodule : tsa_core

`default_nettype wire

// [verif/tsa_core_monitor.sv]
// Assertion checker for the sensor register and alert block.
`timescale 1ns/1ns
`default_nettype none
module tsa_core_monitor (
  input wire logic i_core_clk, // Core clock.
  input wire logic i_rst, // Core reset.
  input wire logic i_lnk_clk, // Link clock.
  input wire logic i_lnk_rst, // Link reset.
  input wire logic i_lnk_req_valid, // Request offered.
  input wire tsa_pkg::lnk_req_t i_lnk_req, // Request kind and byte.
  input wire logic o_lnk_req_ready, // Request can be taken.
  input wire logic o_lnk_rsp_valid, // Answer pulse.
  input wire tsa_pkg::lnk_rsp_t o_lnk_rsp, // Answer ack and byte.
  input wire tsa_pkg::adc_sample_t i_adc_sample, // Converter result.
  input wire logic i_diode_fault, // Remote diode fault.
  input wire logic o_adc_remote, // Remote channel converting.
  input wire logic o_adc_busy, // Converter running.
  input wire logic o_alert_o, // Alert drive level.
  input wire logic o_alert_oe_n // Alert enable, low drives.
);
  // ----------------------------------------------------------------
  // Core domain
  // ----------------------------------------------------------------
  property p_rst_quiet;
    @(posedge i_core_clk) disable iff (i_rst) $fell(i_rst) |-> o_alert_oe_n && !o_adc_busy;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("Active after reset.");
  property p_remote_busy;
    @(posedge i_core_clk) disable iff (i_rst) o_adc_remote |-> o_adc_busy;
  endproperty
  a_remote_busy: assert property (p_remote_busy) else $error("Remote idle.");
  // The pin is open drain, so it may only ever pull low.
  property p_alert_drive;
    @(posedge i_core_clk) disable iff (i_rst) !o_alert_oe_n |-> !o_alert_o;
  endproperty
  a_alert_drive: assert property (p_alert_drive) else $error("Alert drives high.");
  property p_alert_rise;
    @(posedge i_core_clk) disable iff (i_rst)
      $fell(o_alert_oe_n) |-> $past(o_adc_busy) || $past(o_adc_busy, 2);
  endproperty
  a_alert_rise: assert property (p_alert_rise) else $error("Alert without conversion.");
  // ----------------------------------------------------------------
  // Link domain
  // ----------------------------------------------------------------
  property p_rsp_pulse;
    @(posedge i_lnk_clk) disable iff (i_lnk_rst) o_lnk_rsp_valid |=> !o_lnk_rsp_valid;
  endproperty
  a_rsp_pulse: assert property (p_rsp_pulse) else $error("Answer too long.");
  property p_take;
    @(posedge i_lnk_clk) disable iff (i_lnk_rst)
      i_lnk_req_valid && o_lnk_req_ready |=> !o_lnk_req_ready;
  endproperty
  a_take: assert property (p_take) else $error("Request not taken.");
  property p_answer;
    @(posedge i_lnk_clk) disable iff (i_lnk_rst) $fell(o_lnk_req_ready) |-> ##[1:100] o_lnk_rsp_valid;
  endproperty
  a_answer: assert property (p_answer) else $error("No answer.");
  property p_ready_back;
    @(posedge i_lnk_clk) disable iff (i_lnk_rst) o_lnk_rsp_valid |-> o_lnk_req_ready;
  endproperty
  a_ready_back: assert property (p_ready_back) else $error("Ready late.");
  property p_rsp_hold;
    @(posedge i_lnk_clk) disable iff (i_lnk_rst) !o_lnk_rsp_valid |-> $stable(o_lnk_rsp);
  endproperty
  a_rsp_hold: assert property (p_rsp_hold) else $error("Answer moved.");
endmodule : tsa_core_monitor
`default_nettype wire

// [verif/tsa_host_model.sv]
// Host model that issues link requests one at a time.
`timescale 1ns/1ns
`default_nettype none
module tsa_host_model (
  input wire logic i_lnk_clk, // Link clock.
  input wire logic i_req_ready, // Device can take a request.
  input wire logic i_rsp_valid, // Answer pulse.
  input wire tsa_pkg::lnk_rsp_t i_rsp, // Answer ack and byte.
  output logic o_req_valid, // Request offered.
  output tsa_pkg::lnk_req_t o_req // Request kind and byte.
);
  initial
  begin
    o_req_valid = 1'b0;
    o_req = '0;
  end
  task automatic xfer(input tsa_pkg::lnk_kind_t k, input logic [7:0] v,
                      output tsa_pkg::lnk_rsp_t r, output logic ok);
    int n;
    n = 0;
    @(posedge i_lnk_clk);
    o_req_valid <= 1'b1;
    o_req <= '{kind: k, data: v};
    do @(posedge i_lnk_clk); while (!i_req_ready);
    // A released request shows the inverse, so a stale byte is never reused.
    o_req_valid <= 1'b0;
    o_req <= tsa_pkg::lnk_req_t'(~{k, v});
    do
    begin
      @(posedge i_lnk_clk);
      n++;
    end
    while (!i_rsp_valid && n < 200);
    r = i_rsp;
    // A missing answer is handed back as a failed transfer.
    ok = i_rsp_valid;
  endtask : xfer
endmodule : tsa_host_model
`default_nettype wire

// [verif/thermal_sensor_regs_alert_tb.sv]
// Self-checking bench for the sensor register and alert block.
`timescale 1ns/1ns
`default_nettype none
module thermal_sensor_regs_alert_tb;
  localparam logic [6:0] SADDR = 7'h48;
  localparam logic [7:0] MAKER = 8'h3C; // Arbitrary value.
  logic i_core_clk = 1'b0;
  logic i_lnk_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_lnk_rst = 1'b1;
  logic i_lnk_req_valid;
  tsa_pkg::lnk_req_t i_lnk_req;
  logic o_lnk_req_ready;
  logic o_lnk_rsp_valid;
  logic o_adc_remote;
  logic o_adc_busy;
  logic o_alert_o;
  logic o_alert_oe_n;
  tsa_pkg::lnk_rsp_t o_lnk_rsp;
  tsa_pkg::adc_sample_t i_adc_sample = '{below_zero: 1'b0, whole: 8'h50, frac: 2'b10};
  logic i_diode_fault = 1'b0;
  tsa_pkg::lnk_rsp_t r;
  int num_errors = 0;
  int compares = 0;
  // ----------------------------------------------------------------
  // Clocks, design and host
  // ----------------------------------------------------------------
  always #50 i_core_clk = ~i_core_clk;
  // The link clock starts off the core grid to keep the phases unrelated.
  initial
  begin
    #1;
    forever #3 i_lnk_clk = ~i_lnk_clk;
  end
  tsa_core #(.CONV_CYCLES(20), .SLAVE_ADDR(SADDR), .MAKER_ID(MAKER)) u_tsa_core (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_lnk_clk(i_lnk_clk), .i_lnk_rst(i_lnk_rst),
    .i_lnk_req_valid(i_lnk_req_valid), .i_lnk_req(i_lnk_req), .o_lnk_req_ready(o_lnk_req_ready),
    .o_lnk_rsp_valid(o_lnk_rsp_valid), .o_lnk_rsp(o_lnk_rsp), .i_adc_sample(i_adc_sample),
    .i_diode_fault(i_diode_fault), .o_adc_remote(o_adc_remote), .o_adc_busy(o_adc_busy),
    .o_alert_o(o_alert_o), .o_alert_oe_n(o_alert_oe_n));
  tsa_host_model u_tsa_host_model (.i_lnk_clk(i_lnk_clk), .i_req_ready(o_lnk_req_ready),
    .i_rsp_valid(o_lnk_rsp_valid), .i_rsp(o_lnk_rsp), .o_req_valid(i_lnk_req_valid),
    .o_req(i_lnk_req));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e)
    begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask : cyc
  // A transfer that never gets its answer counts as a mismatch and ends the run.
  task automatic xf(input tsa_pkg::lnk_kind_t k, input logic [7:0] v);
    logic ok;
    u_tsa_host_model.xfer(k, v, r, ok);
    if (!ok)
    begin
      num_errors++;
      close_out();
    end
  endtask : xf
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    xf(tsa_pkg::KIND_CMD, a);
    xf(tsa_pkg::KIND_DATA, v);
  endtask : wr
  // Read Byte, then compare the bits picked by the mask.
  task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    xf(tsa_pkg::KIND_CMD, a);
    xf(tsa_pkg::KIND_READ, 8'h00);
    chk(r.data & m, e);
  endtask : rc
  // Single shot, then wait out both channels.
  task automatic shot();
    xf(tsa_pkg::KIND_CMD, tsa_pkg::REG_ONE_CONV);
    chk({7'h00, o_adc_busy}, 8'h01);
    cyc(60);
    chk({7'h00, o_adc_busy}, 8'h00);
  endtask : shot
  task automatic al(input logic e);
    cyc(4);
    chk({7'h00, o_alert_oe_n}, {7'h00, e});
  endtask : al
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    #1000000;
    num_errors++;
    close_out();
  end
  initial
  begin
    repeat (16) @(posedge i_core_clk);
    i_rst <= 1'b0;
    i_lnk_rst <= 1'b0;
    xf(tsa_pkg::KIND_READ, 8'h00);
    chk(r.data, 8'h00);
    rc(8'h03, 8'hFF, 8'h10);
    rc(8'h05, 8'hFF, 8'h46);
    rc(8'h07, 8'hFF, 8'h78);
    cyc(200);
    al(1'b0);
    $display("Test reset values done");
    wr(8'h09, 8'h40);
    cyc(2);
    chk({7'h00, o_adc_busy}, 8'h00);
    cyc(60);
    rc(8'h00, 8'hFF, 8'h50);
    rc(8'h01, 8'hFF, 8'h50);
    rc(8'h10, 8'hFF, 8'h80);
    rc(8'h11, 8'hFF, 8'h80);
    rc(8'h02, 8'h7F, 8'h40);
    al(1'b0);
    wr(8'h0D, 8'h40);
    rc(8'h07, 8'hFF, 8'h40);
    xf(tsa_pkg::KIND_ARA, 8'h00);
    chk({7'h00, r.ack}, 8'h01);
    chk(r.data, {SADDR, 1'b0});
    al(1'b1);
    shot();
    al(1'b0);
    rc(8'h02, 8'h7F, 8'h50);
    rc(8'h02, 8'h80, 8'h00);
    wr(8'h0B, 8'h60);
    wr(8'h0D, 8'h60);
    al(1'b1);
    rc(8'h05, 8'hFF, 8'h60);
    rc(8'h02, 8'hFF, 8'h00);
    $display("Test alert done");
    i_diode_fault <= 1'b1;
    shot();
    rc(8'h01, 8'hFF, 8'hFF);
    rc(8'h02, 8'h04, 8'h04);
    al(1'b1);
    i_diode_fault <= 1'b0;
    cyc(4);
    rc(8'h02, 8'h04, 8'h04);
    rc(8'h02, 8'hFF, 8'h00);
    $display("Test diode fault done");
    wr(8'h09, 8'hC0);
    wr(8'h0B, 8'h10);
    shot();
    al(1'b1);
    rc(8'h02, 8'h7F, 8'h40);
    i_adc_sample <= '{below_zero: 1'b1, whole: 8'h20, frac: 2'b00};
    shot();
    rc(8'h00, 8'hFF, 8'h00);
    wr(8'h09, 8'h4F);
    rc(8'h03, 8'hFF, 8'h40);
    rc(8'h04, 8'hFF, 8'h00);
    rc(8'hFE, 8'hFF, MAKER);
    // Remote only: the local result must stay as it was.
    i_adc_sample <= '{below_zero: 1'b0, whole: 8'h30, frac: 2'b01};
    wr(8'h09, 8'h60);
    xf(tsa_pkg::KIND_CMD, tsa_pkg::REG_ONE_CONV);
    chk({7'h00, o_adc_remote}, 8'h01);
    rc(8'h02, 8'h80, 8'h80);
    cyc(30);
    rc(8'h01, 8'hFF, 8'h30);
    rc(8'h00, 8'hFF, 8'h00);
    rc(8'h10, 8'hFF, 8'h40);
    $display("Test mask and reserved done");
    close_out();
  end
endmodule : thermal_sensor_regs_alert_tb
bind tsa_core tsa_core_monitor u_tsa_core_monitor (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_lnk_clk(i_lnk_clk), .i_lnk_rst(i_lnk_rst),
  .i_lnk_req_valid(i_lnk_req_valid), .i_lnk_req(i_lnk_req), .o_lnk_req_ready(o_lnk_req_ready),
  .o_lnk_rsp_valid(o_lnk_rsp_valid), .o_lnk_rsp(o_lnk_rsp), .i_adc_sample(i_adc_sample),
  .i_diode_fault(i_diode_fault), .o_adc_remote(o_adc_remote), .o_adc_busy(o_adc_busy),
  .o_alert_o(o_alert_o), .o_alert_oe_n(o_alert_oe_n));
`default_nettype wire
